// File: hw/tsp_host_port.sv
// Serial host port and status signalling of the touch converter
// What this block does
// - Input bits accepted only while slave select is low; ignored otherwise.
// - Serial output released to high impedance while slave select is high.
// - Each input bit is captured at a serial clock falling edge.
// - Each output bit is shifted out at a serial clock falling edge.
// - Control by 16-bit register writes, selected by a leading command word.
// - Active-low data-available output asserts once a measurement result is ready.
// - Keypad interrupt output signals that a key has been pressed.
// - Pen interrupt output signals that a screen touch was detected.
// - Results sit in result registers the host may read at any time.
// - Register contents steer the converter, current DAC and key scanner.
// - Keypad interrupt is active low, driven low on a key press.
module tsp_host_port
  import tsp_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                sclk,
  input  wire logic                ss_n,
  input  wire logic                mosi,
  output logic                     miso,
  output logic                     miso_oe_n,
  input  wire logic                conv_done,
  input  wire tsp_pkg::tsp_res_s   result_wr,
  input  wire logic                key_down,
  input  wire logic                touch_down,
  output logic                     result_ready_n,
  output logic                     key_press_irq_n,
  output logic                     touch_detect_irq,
  output tsp_pkg::tsp_cfg_s        cfg
);

  // ****************************************
  // Pin synchronisation and edge detection
  // ****************************************
  logic [2:0] pins_s;
  logic       sclk_s;
  logic       ss_s;
  logic       mosi_s;
  logic       sclk_d_r;
  logic       fall;
  logic       active;

  // The serial clock is sampled like data, so it must stay well below mclk
  tsp_sync #(.W(3)) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({sclk, ss_n, mosi}),
    .q    (pins_s)
  );

  assign sclk_s = pins_s[2];
  assign ss_s   = pins_s[1];
  assign mosi_s = pins_s[0];

  // Delayed clock copy; resets to the idle level so reset makes no edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // Clock edges only count inside a frame; the clock pin is only sampled
  assign fall   = sclk_d_r & ~sclk_s;
  assign active = fall & ~ss_s;

  // ****************************************
  // Frame state: command word then data words
  // ****************************************
  tsp_phase_e        phase_r;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [WORD_W-1:0] rx_r;
  logic [WORD_W-1:0] rx_nxt;
  logic              rd_r;
  logic [ADDR_W-1:0] addr_r;
  logic              word_done;

  assign rx_nxt    = {rx_r[WORD_W-2:0], mosi_s};
  assign word_done = active && (bit_cnt_r == LAST_BIT);

  // Input shifter, fed only by falling edges inside a frame
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_r <= '0;
    end else if (active) begin
      rx_r <= rx_nxt;
    end
  end

  // Bit counter and phase; a rising select abandons a partial word
  always_ff @(posedge mclk) begin
    if (rst) begin
      bit_cnt_r <= '0;
      phase_r   <= PH_CMD;
    end else if (ss_s) begin
      bit_cnt_r <= '0;
      phase_r   <= PH_CMD;
    end else if (active) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r == LAST_BIT) begin
        phase_r <= PH_DATA;
      end
    end
  end

  // Command decode and address auto-increment across data words
  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_r   <= 1'b0;
      addr_r <= '0;
    end else if (word_done) begin
      case (phase_r)
        PH_CMD: begin
          rd_r   <= rx_nxt[CMD_RD_BIT];
          addr_r <= rx_nxt[ADDR_W-1:0];
        end
        PH_DATA: begin
          addr_r <= addr_r + 6'h01;
        end
        default: begin
          addr_r <= addr_r;
        end
      endcase
    end
  end

  // ****************************************
  // Host writes and result writes
  // ****************************************
  logic              hw_pend_r;
  logic [ADDR_W-1:0] hw_addr_r;
  logic [WORD_W-1:0] hw_data_r;
  logic              hw_go;
  logic              host_wr_done;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_waddr;
  logic [WORD_W-1:0] mem_wdata;
  logic [WORD_W-1:0] rd_data;

  // Result registers are read-only to the host
  assign host_wr_done = word_done && (phase_r == PH_DATA) && !rd_r
                        && (addr_r < ADR_RES_BASE);

  // A result write takes the port first; the host write waits until no result write is valid
  assign hw_go     = hw_pend_r & ~result_wr.valid;
  assign mem_we    = result_wr.valid | hw_go;
  assign mem_waddr = result_wr.valid ? result_wr.addr : hw_addr_r;
  assign mem_wdata = result_wr.valid ? result_wr.data : hw_data_r;

  // Pending host write; words are 16 edges apart so it never stacks
  always_ff @(posedge mclk) begin
    if (rst) begin
      hw_pend_r <= 1'b0;
      hw_addr_r <= '0;
      hw_data_r <= '0;
    end else if (host_wr_done) begin
      hw_pend_r <= 1'b1;
      hw_addr_r <= addr_r;
      hw_data_r <= rx_nxt;
    end else if (hw_go) begin
      hw_pend_r <= 1'b0;
    end
  end

  tsp_regmem #(.AW(ADDR_W), .DW(WORD_W)) u_mem (
    .mclk  (mclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (addr_r),
    .rdata (rd_data)
  );

  // Control mirrors drive the engines directly, no memory latency
  always_ff @(posedge mclk) begin
    if (rst) begin
      cfg <= {CTRL_RST, CTRL_RST, CTRL_RST};
    end else if (hw_go) begin
      case (hw_addr_r)
        ADR_ADC_CTRL: cfg.adc <= hw_data_r;
        ADR_DAC_CTRL: cfg.dac <= hw_data_r;
        ADR_KEY_CTRL: cfg.key <= hw_data_r;
        default:      cfg     <= cfg;
      endcase
    end
  end

  // ****************************************
  // Serial output
  // ****************************************
  logic [WORD_W-1:0] tx_r;
  logic [1:0]        ld_dly_r;
  logic              rd_start;

  // A read word is fetched after the command and after each read word
  assign rd_start = word_done && (phase_r == PH_CMD ? rx_nxt[CMD_RD_BIT]
                                                    : rd_r);

  // Two cycles: address register settles, then memory output register
  always_ff @(posedge mclk) begin
    if (rst) begin
      ld_dly_r <= '0;
    end else begin
      ld_dly_r <= {ld_dly_r[0], rd_start};
    end
  end

  // Result words can be fetched at any moment, no handshake needed
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_r <= '0;
    end else if (ld_dly_r[1]) begin
      tx_r <= rd_data;
    end else if (active) begin
      tx_r <= {tx_r[WORD_W-2:0], 1'b0};
    end
  end

  // Released whenever the synchronised select is high
  assign miso      = tx_r[WORD_W-1];
  assign miso_oe_n = ss_s;

  // ****************************************
  // Status outputs
  // ****************************************
  logic rr_r;
  logic res_read;
  logic key_r;
  logic touch_r;

  assign res_read = word_done && (phase_r == PH_DATA) && rd_r
                    && (addr_r >= ADR_RES_BASE);

  // Data-available flag: a new result wins over a read that clears it
  always_ff @(posedge mclk) begin
    if (rst) begin
      rr_r <= 1'b0;
    end else if (conv_done) begin
      rr_r <= 1'b1;
    end else if (res_read) begin
      rr_r <= 1'b0;
    end
  end

  // Key and touch detect levels come from same-clock engines
  always_ff @(posedge mclk) begin
    if (rst) begin
      key_r   <= 1'b0;
      touch_r <= 1'b0;
    end else begin
      key_r   <= key_down;
      touch_r <= touch_down;
    end
  end

  assign result_ready_n   = ~rr_r;
  assign key_press_irq_n  = ~key_r;
  assign touch_detect_irq = touch_r;

  // ****************************************
  // Assertions
  // ****************************************
  AST_MISO_RELEASED: assert property (@(posedge mclk) disable iff (rst)
    $past(ss_n, 2) |-> miso_oe_n)
    else $error("serial output driven while select high");

  AST_IGNORE_IDLE: assert property (@(posedge mclk) disable iff (rst)
    ss_s |=> $stable(rx_r))
    else $error("input bits taken while select high");

  AST_CAPTURE_FALL: assert property (@(posedge mclk) disable iff (rst)
    active |=> rx_r[0] == $past(mosi_s))
    else $error("input bit not captured at falling edge");

  AST_SHIFT_FALL: assert property (@(posedge mclk) disable iff (rst)
    (!active && !ld_dly_r[1]) |=> $stable(tx_r))
    else $error("output moved away from a falling edge");

  AST_CMD_LEN: assert property (@(posedge mclk) disable iff (rst)
    (word_done && phase_r == PH_CMD) |=> phase_r == PH_DATA)
    else $error("command word not 16 bits");

  AST_ABORT: assert property (@(posedge mclk) disable iff (rst)
    $rose(ss_s) |=> (bit_cnt_r == '0) && (phase_r == PH_CMD))
    else $error("partial transfer not abandoned");

  AST_RESULT_READY: assert property (@(posedge mclk) disable iff (rst)
    conv_done |=> !result_ready_n)
    else $error("data available not asserted");

  AST_KEY_IRQ: assert property (@(posedge mclk) disable iff (rst)
    key_down |=> !key_press_irq_n)
    else $error("key press not signalled low");

  AST_TOUCH_IRQ: assert property (@(posedge mclk) disable iff (rst)
    touch_down |=> touch_detect_irq)
    else $error("touch not signalled");

  AST_READ_LOAD: assert property (@(posedge mclk) disable iff (rst)
    rd_start |-> ##3 tx_r === $past(rd_data))
    else $error("read word not loaded");

  AST_CFG_ADC: assert property (@(posedge mclk) disable iff (rst)
    (hw_go && hw_addr_r == ADR_ADC_CTRL) |=> cfg.adc == $past(hw_data_r))
    else $error("converter control not updated");

  COV_READ: cover property (@(posedge mclk) disable iff (rst)
    ld_dly_r[1] ##[1:40] active);
  COV_WRITE: cover property (@(posedge mclk) disable iff (rst)
    hw_go);
  COV_ABORT: cover property (@(posedge mclk) disable iff (rst)
    (bit_cnt_r != '0) ##1 $rose(ss_s));
  COV_RESULT_CLEAR: cover property (@(posedge mclk) disable iff (rst)
    rr_r ##1 res_read ##1 !rr_r);

endmodule : tsp_host_port

// File: hw/tsp_pkg.sv
// Shared constants and types for the touch converter serial host port
package tsp_pkg;

  // ****************************************
  // Widths and register map
  // ****************************************
  localparam int          WORD_W       = 16;
  localparam int          ADDR_W       = 6;
  localparam int          CNT_W        = 4;
  localparam int          CMD_RD_BIT   = 15;
  localparam logic [3:0]  LAST_BIT     = 4'hF;
  localparam logic [5:0]  ADR_ADC_CTRL = 6'h00;
  localparam logic [5:0]  ADR_DAC_CTRL = 6'h01;
  localparam logic [5:0]  ADR_KEY_CTRL = 6'h02;
  localparam logic [5:0]  ADR_RES_BASE = 6'h20;
  localparam logic [15:0] CTRL_RST     = 16'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {PH_CMD, PH_DATA} tsp_phase_e;

  // Result write from the measurement engine
  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } tsp_res_s;

  // Control words steering the converter, current DAC and key scanner
  typedef struct packed {
    logic [WORD_W-1:0] adc;
    logic [WORD_W-1:0] dac;
    logic [WORD_W-1:0] key;
  } tsp_cfg_s;

endpackage : tsp_pkg

// File: hw/tsp_sync.sv
// Two flip-flop synchroniser, one per bit
module tsp_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ****************************************
  // Per-bit stages
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic q_r;
      // First stage feeds only the second stage
      always_ff @(posedge mclk) begin
        if (rst) begin
          meta_r <= 1'b1;
          q_r    <= 1'b1;
        end else begin
          meta_r <= d[i];
          q_r    <= meta_r;
        end
      end
      assign q[i] = q_r;
    end
  endgenerate

endmodule : tsp_sync

// File: hw/tsp_regmem.sv
// Register memory with one write port and a registered read port
module tsp_regmem #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  input  wire logic          mclk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // ****************************************
  // Storage
  // ****************************************
  // Contents are not reset; software reads unknown data until written
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Read data always comes out of a register
  always_ff @(posedge mclk) begin
    rdata_r <= mem[raddr];
  end

  assign rdata = rdata_r;

endmodule : tsp_regmem

// File: tb/tsp_host_model.sv
// Host side model: serial bus master of the device's link pins
module tsp_host_model (
  input  wire logic mclk,
  input  wire logic miso_w,
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Link drivers
  // ****************************************
  // Clock idles high and stands still except while shift runs, even outside a frame
  initial begin
    sclk = 1'b1;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // Select the device and hold before the first clock fall
  task automatic sel();
    @(posedge mclk);
    ss_n <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask : sel

  // Release select; a released line shows the inverse of its last value
  task automatic desel();
    repeat (8) @(posedge mclk);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (8) @(posedge mclk);
  endtask : desel

  // Shift nb bits MSB first; high phases of 9 and low phases of 8 cycles keep well above sampling
  task automatic shift(input logic [15:0] tx, input int nb,
                       output logic [15:0] rx);
    rx = '0;
    for (int i = 15; i > 15 - nb; i--) begin
      @(posedge mclk);
      mosi <= tx[i];
      repeat (8) @(posedge mclk);
      // The device launches on the fall, so the line still shows the bit
      // that stood at the previous rise; sampling here keeps words aligned
      rx = {rx[14:0], miso_w};
      sclk <= 1'b0;
      repeat (8) @(posedge mclk);
      sclk <= 1'b1;
    end
  endtask : shift

endmodule : tsp_host_model

// File: tb/tsp_host_port_test.sv
// Self-checking bench of the serial host port
module tsp_host_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  import tsp_pkg::*;

  localparam int TMO = 20000;

  logic     mclk;
  logic     rst;
  logic     sclk;
  logic     ss_n;
  logic     mosi;
  logic     miso;
  logic     miso_oe_n;
  logic     miso_w;
  logic     miso_last;
  logic     conv_done;
  tsp_res_s result_wr;
  logic     key_down;
  logic     touch_down;
  logic     result_ready_n;
  logic     key_press_irq_n;
  logic     touch_detect_irq;
  tsp_cfg_s cfg;
  int       miscompares;
  int       num_checks;
  int       cycles;
  logic [47:0] rd;

  // ****************************************
  // Instances and wire
  // ****************************************
  tsp_host_port i_tsp_host_port (
    .mclk(mclk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso(miso), .miso_oe_n(miso_oe_n), .conv_done(conv_done),
    .result_wr(result_wr), .key_down(key_down), .touch_down(touch_down),
    .result_ready_n(result_ready_n), .key_press_irq_n(key_press_irq_n),
    .touch_detect_irq(touch_detect_irq), .cfg(cfg));

  tsp_host_model i_tsp_host_model (
    .mclk(mclk), .miso_w(miso_w), .sclk(sclk), .ss_n(ss_n), .mosi(mosi));

  // Undriven line never holds its value, so stale data cannot pass
  always_ff @(posedge mclk) begin
    if (!miso_oe_n) miso_last <= miso;
  end
  assign miso_w = miso_oe_n ? ~miso_last : miso;

  // Clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == TMO) begin
      miscompares++;
      complete_run();
    end
  end

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One frame: command word then n data words
  task automatic frame(input logic r, input logic [5:0] a, input int n,
                       input logic [47:0] wd, output logic [47:0] rv);
    logic [15:0] rx;
    rv = '0;
    i_tsp_host_model.sel();
    i_tsp_host_model.shift({r, 9'h000, a}, 16, rx);
    for (int k = 0; k < n; k++) begin
      i_tsp_host_model.shift(wd[47-16*k -: 16], 16, rx);
      rv = {rv[31:0], rx};
    end
    i_tsp_host_model.desel();
    #1;
  endtask : frame

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    #1;
    chk({miso_oe_n, result_ready_n, key_press_irq_n, touch_detect_irq},
        48'h000E);
    chk(cfg, 48'h0);
  endtask : t_reset

  task automatic t_cfg();
    frame(1'b0, 6'h00, 3, 48'hA55A_0F0F_8001, rd);
    chk(cfg, 48'hA55A_0F0F_8001);
    frame(1'b1, 6'h00, 3, 48'h0, rd);
    chk(rd, 48'hA55A_0F0F_8001);
  endtask : t_cfg

  // Clocking while deselected must change nothing
  task automatic t_ignore();
    logic [15:0] rx;
    i_tsp_host_model.shift(16'h0001, 16, rx);
    i_tsp_host_model.shift(16'hFFFF, 16, rx);
    #1;
    chk(miso_oe_n, 48'h1);
    chk(cfg, 48'hA55A_0F0F_8001);
  endtask : t_ignore

  // Partial command dropped, then a clean frame must land correctly
  task automatic t_abort();
    logic [15:0] rx;
    i_tsp_host_model.sel();
    i_tsp_host_model.shift(16'h0001, 7, rx);
    #1;
    chk(miso_oe_n, 48'h0);
    i_tsp_host_model.desel();
    #1;
    chk(miso_oe_n, 48'h1);
    frame(1'b0, 6'h02, 1, 48'h1234_0000_0000, rd);
    chk(cfg, 48'hA55A_0F0F_1234);
  endtask : t_abort

  task automatic t_result();
    @(posedge mclk);
    result_wr <= {1'b1, 6'h20, 16'hC3C3};
    @(posedge mclk);
    result_wr <= {1'b1, 6'h21, 16'h3C3C};
    @(posedge mclk);
    result_wr <= '0;
    conv_done <= 1'b1;
    @(posedge mclk);
    conv_done <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(result_ready_n, 48'h0);
    frame(1'b0, 6'h20, 1, 48'hFFFF_0000_0000, rd);
    chk(result_ready_n, 48'h0);
    frame(1'b1, 6'h20, 2, 48'h0, rd);
    chk(rd, 48'h0000_C3C3_3C3C);
    chk(result_ready_n, 48'h1);
  endtask : t_result

  task automatic t_status();
    @(posedge mclk);
    key_down   <= 1'b1;
    touch_down <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({key_press_irq_n, touch_detect_irq}, 48'h1);
    @(posedge mclk);
    key_down   <= 1'b0;
    touch_down <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk({key_press_irq_n, touch_detect_irq}, 48'h2);
  endtask : t_status

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    conv_done = 1'b0;
    result_wr = '0;
    key_down = 1'b0;
    touch_down = 1'b0;
    miscompares = 0;
    num_checks = 0;
    cycles = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    t_reset();
    t_cfg();
    t_ignore();
    t_abort();
    t_result();
    t_status();
    complete_run();
  end

endmodule : tsp_host_port_test
